// ===== gsr_defs.svh
// Constants for the status-reporting command block: bit positions,
// command codes, reset values and widths.
// Assumes inclusion by bare name from the package and the design file.
`ifndef GSR_DEFS_SVH
`define GSR_DEFS_SVH
`define GSR_EVT_OPC_BIT 3'd0
`define GSR_EVT_QERR_BIT 3'd3
`define GSR_EVT_EXERR_BIT 3'd4
`define GSR_EVT_CMERR_BIT 3'd5
`define GSR_EVT_PWR_BIT 3'd7
`define GSR_SB_COND_BIT 3'd0
`define GSR_SB_MAV_BIT 3'd4
`define GSR_SB_ESB_BIT 3'd5
`define GSR_SB_MSS_BIT 3'd6
`define GSR_MASK_RESET 8'h00
`define GSR_EVT_RESET 8'h80
`define GSR_COND_W 8
`define GSR_TST_ANSWER 8'h00
`define GSR_OP_WAI 4'h0
`define GSR_OP_EVMASK_SET 4'h1
`define GSR_OP_EVMASK_QRY 4'h2
`define GSR_OP_OPC 4'h3
`define GSR_OP_SRMASK_SET 4'h4
`define GSR_OP_SRMASK_QRY 4'h5
`define GSR_OP_STATUS_QRY 4'h6
`define GSR_OP_TST_QRY 4'h7
`define GSR_OP_CONDMASK_SET 4'h8
`define GSR_OP_CONDMASK_QRY 4'h9
`define GSR_OP_EVENT_QRY 4'ha
`endif

// ===== gsr_pkg.sv
// Types for the status-reporting command block.
// Assumes gsr_defs.svh is on the include path.
`include "gsr_defs.svh"
package gsr_pkg;
  // Command opcodes issued by the command parser
  typedef enum logic [3:0]
  {
    gsr_wai_type_c = `GSR_OP_WAI,
    gsr_evmask_set = `GSR_OP_EVMASK_SET,
    gsr_evmask_qry = `GSR_OP_EVMASK_QRY,
    gsr_opc = `GSR_OP_OPC,
    gsr_srmask_set = `GSR_OP_SRMASK_SET,
    gsr_srmask_qry = `GSR_OP_SRMASK_QRY,
    gsr_status_qry = `GSR_OP_STATUS_QRY,
    gsr_tst_qry = `GSR_OP_TST_QRY,
    gsr_condmask_set = `GSR_OP_CONDMASK_SET,
    gsr_condmask_qry = `GSR_OP_CONDMASK_QRY,
    gsr_event_qry = `GSR_OP_EVENT_QRY
  } gsr_op_type;

  // One command as delivered by the parser
  typedef struct packed
  {
    logic valid;
    logic from_gpib;
    gsr_op_type op;
    logic [7:0] value;
  } gsr_cmd_type;

  // One answer to a query
  typedef struct packed
  {
    logic valid;
    logic [7:0] value;
  } gsr_rsp_type;

  // Error events from the parser and executor
  typedef struct packed
  {
    logic query_err;
    logic exec_err;
    logic cmd_err;
  } gsr_err_type;
endpackage : gsr_pkg

// ===== gsr_status.sv
// Status byte, event status and enable masks for the GPIB status model,
// plus the fixed common-command answers.
// Assumes a parser on the same clock delivering decoded commands and
// a condition register from the same clock domain.
`include "gsr_defs.svh"

// Overview of operation
// - Commands act only when from GPIB
// - Wait command accepted, does nothing
// - Event enable set loads mask value
// - Event bits: 0 opc,3 query,4 exec,5 cmd
// - Enabled event bit sets status bit 5
// - Event enable query returns mask unchanged
// - Operation complete sets event bit 0
// - Service enable mask loads, gates bits
// - Service enable query returns mask
// - Enabled condition bit sets status bit 0
// - Response available sets status bit 4
// - Bit 6 summary; status query returns byte
// - Self-test query always answers zero
// - Condition enable mask loads on set
// - Condition enable query returns mask
// - Event query returns and clears register
// - Bit 7 on power-on and GPIB enable
module gsr_status
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command in, answer out
  input wire gsr_pkg::gsr_cmd_type cmd,
  output gsr_pkg::gsr_rsp_type rsp,
  // Status inputs
  input wire gsr_pkg::gsr_err_type err,
  input wire logic msg_avail,
  input wire logic gpib_enabled,
  input wire logic [7:0] condition_register,
  // Status outputs
  output logic [7:0] status_byte,
  output logic service_request
);
  logic [7:0] event_enable_mask_reg;
  logic [7:0] service_request_enable_mask_reg;
  logic [7:0] condition_enable_mask_reg;
  logic [7:0] event_status_register_reg;
  logic [7:0] event_status_register_next;
  logic gpib_en_reg;
  logic gpib_seen_reg;
  logic act;
  logic evt_read;
  logic [7:0] sb_low;
  logic mss;
  logic [7:0] rsp_value_next;
  logic rsp_valid_next;

  // Bitwise enable then OR-reduce, used for every summary bit
  function automatic logic gsr_any(input logic [7:0] bits,
    input logic [7:0] mask);
    gsr_any = |(bits & mask);
  endfunction : gsr_any

  // Full status byte: live low bits with the summary in bit 6
  function automatic logic [7:0] gsr_with_summary(input logic [7:0] bits,
    input logic summary);
    gsr_with_summary = bits | ({7'h00, summary} << `GSR_SB_MSS_BIT);
  endfunction : gsr_with_summary

  // Commands count only when they arrive from the GPIB side
  assign act = cmd.valid && cmd.from_gpib;
  assign evt_read = act && (cmd.op == gsr_pkg::gsr_event_qry);

  // Enable masks; all clear on reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      event_enable_mask_reg <= `GSR_MASK_RESET;
      service_request_enable_mask_reg <= `GSR_MASK_RESET;
      condition_enable_mask_reg <= `GSR_MASK_RESET;
    end
    else if (act)
    begin
      if (cmd.op == gsr_pkg::gsr_evmask_set)
        event_enable_mask_reg <= cmd.value;
      if (cmd.op == gsr_pkg::gsr_srmask_set)
        service_request_enable_mask_reg <= cmd.value;
      if (cmd.op == gsr_pkg::gsr_condmask_set)
        condition_enable_mask_reg <= cmd.value;
    end
  end

  // Interface-enable tracking; first sample after reset is not an edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gpib_en_reg <= 1'b0;
      gpib_seen_reg <= 1'b0;
    end
    else
    begin
      gpib_en_reg <= gpib_enabled;
      gpib_seen_reg <= 1'b1;
    end
  end

  // Event status: read clears, new events win over the clear
  always_comb
  begin
    event_status_register_next = event_status_register_reg;
    if (evt_read)
      event_status_register_next = 8'h00;
    if (act && cmd.op == gsr_pkg::gsr_opc)
      event_status_register_next[`GSR_EVT_OPC_BIT] = 1'b1;
    if (err.query_err)
      event_status_register_next[`GSR_EVT_QERR_BIT] = 1'b1;
    if (err.exec_err)
      event_status_register_next[`GSR_EVT_EXERR_BIT] = 1'b1;
    if (err.cmd_err)
      event_status_register_next[`GSR_EVT_CMERR_BIT] = 1'b1;
    if (gpib_seen_reg && gpib_enabled && !gpib_en_reg)
      event_status_register_next[`GSR_EVT_PWR_BIT] = 1'b1;
  end

  // Power-on leaves bit 7 set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      event_status_register_reg <= `GSR_EVT_RESET;
    else
      event_status_register_reg <= event_status_register_next;
  end

  // Status byte built live from current state
  always_comb
  begin
    sb_low = 8'h00;
    sb_low[`GSR_SB_COND_BIT] = gsr_any(condition_register,
      condition_enable_mask_reg);
    sb_low[`GSR_SB_MAV_BIT] = msg_avail;
    sb_low[`GSR_SB_ESB_BIT] = gsr_any(event_status_register_reg,
      event_enable_mask_reg);
  end

  // Summary from enabled status bits, bit 6 excluded from its own cause
  assign mss = gsr_any(sb_low, service_request_enable_mask_reg);

  // Status byte and service request registered for clean outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_byte <= 8'h00;
      service_request <= 1'b0;
    end
    else
    begin
      status_byte <= gsr_with_summary(sb_low, mss);
      service_request <= mss;
    end
  end

  // Query answers
  always_comb
  begin
    rsp_valid_next = 1'b0;
    rsp_value_next = 8'h00;
    if (act)
    begin
      unique case (cmd.op)
        gsr_pkg::gsr_evmask_qry:
        begin
          rsp_valid_next = 1'b1;
          rsp_value_next = event_enable_mask_reg;
        end
        gsr_pkg::gsr_srmask_qry:
        begin
          rsp_valid_next = 1'b1;
          rsp_value_next = service_request_enable_mask_reg;
        end
        gsr_pkg::gsr_status_qry:
        begin
          rsp_valid_next = 1'b1;
          rsp_value_next = gsr_with_summary(sb_low, mss);
        end
        gsr_pkg::gsr_tst_qry:
        begin
          rsp_valid_next = 1'b1;
          rsp_value_next = `GSR_TST_ANSWER;
        end
        gsr_pkg::gsr_condmask_qry:
        begin
          rsp_valid_next = 1'b1;
          rsp_value_next = condition_enable_mask_reg;
        end
        gsr_pkg::gsr_event_qry:
        begin
          rsp_valid_next = 1'b1;
          rsp_value_next = event_status_register_reg;
        end
        default:
        begin
          // Wait command and set commands give no answer
          rsp_valid_next = 1'b0;
        end
      endcase
    end
  end

  // Answer register, one-cycle valid pulse
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rsp <= '0;
    else
    begin
      rsp.valid <= rsp_valid_next;
      rsp.value <= rsp_value_next;
    end
  end

  // Set command loads the event mask next cycle
  property p_evmask_load;
    @(posedge clk) disable iff (!rst_b)
    act && cmd.op == gsr_pkg::gsr_evmask_set
      |=> event_enable_mask_reg == $past(cmd.value);
  endproperty
  a_evmask_load: assert property (p_evmask_load)
    else $error("event mask not loaded");

  // Non-GPIB commands change no mask
  property p_non_gpib;
    @(posedge clk) disable iff (!rst_b)
    cmd.valid && !cmd.from_gpib
      |=> $stable(event_enable_mask_reg)
        && $stable(service_request_enable_mask_reg)
        && $stable(condition_enable_mask_reg) && !rsp.valid;
  endproperty
  a_non_gpib: assert property (p_non_gpib)
    else $error("non-GPIB command took effect");

  // Operation complete sets bit 0
  property p_opc;
    @(posedge clk) disable iff (!rst_b)
    act && cmd.op == gsr_pkg::gsr_opc |=> event_status_register_reg[0];
  endproperty
  a_opc: assert property (p_opc)
    else $error("opc did not set bit 0");

  // Event query answers old value and clears
  sequence s_evt_q;
    act && cmd.op == gsr_pkg::gsr_event_qry && err == '0
      && !(gpib_enabled && !gpib_en_reg);
  endsequence
  property p_evt_clear;
    @(posedge clk) disable iff (!rst_b)
    s_evt_q |=> rsp.valid && rsp.value == $past(event_status_register_reg)
      && event_status_register_reg == 8'h00;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("event query did not clear");

  // Self-test answers zero
  property p_tst;
    @(posedge clk) disable iff (!rst_b)
    act && cmd.op == gsr_pkg::gsr_tst_qry |=> rsp.valid && rsp.value == 8'h00;
  endproperty
  a_tst: assert property (p_tst)
    else $error("self-test answer not zero");

  // Service request follows enabled status bits
  property p_srq;
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> service_request == |($past(sb_low)
      & $past(service_request_enable_mask_reg));
  endproperty
  a_srq: assert property (p_srq)
    else $error("service request wrong");

  // Status bit 6 is the summary of the enabled status bits
  property p_mss;
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> status_byte[6] == service_request
      && status_byte[6] == |((status_byte & 8'hbf)
        & $past(service_request_enable_mask_reg));
  endproperty
  a_mss: assert property (p_mss)
    else $error("summary bit disagrees with request");

  // Enabled event bit shows in status bit 5
  property p_esb;
    @(posedge clk) disable iff (!rst_b)
    |(event_status_register_reg & event_enable_mask_reg) |=> status_byte[5];
  endproperty
  a_esb: assert property (p_esb)
    else $error("status bit 5 missing");

  // Message available shows in status bit 4 one edge on
  property p_mav;
    @(posedge clk) disable iff (!rst_b)
    msg_avail |=> status_byte[4];
  endproperty
  a_mav: assert property (p_mav)
    else $error("status bit 4 missing");

  // Condition enable query returns mask
  property p_condmask_q;
    @(posedge clk) disable iff (!rst_b)
    act && cmd.op == gsr_pkg::gsr_condmask_qry
      |=> rsp.valid && rsp.value == $past(condition_enable_mask_reg);
  endproperty
  a_condmask_q: assert property (p_condmask_q)
    else $error("condition mask query wrong");

  // Wait command answers nothing and moves neither the event nor the service request mask
  property p_wai;
    @(posedge clk) disable iff (!rst_b)
    act && cmd.op == gsr_pkg::gsr_wai_type_c
      |=> !rsp.valid && $stable(event_enable_mask_reg)
        && $stable(service_request_enable_mask_reg);
  endproperty
  a_wai: assert property (p_wai)
    else $error("wait command had an effect");

  // Each error pulse lands on its own event bit
  property p_err_bits;
    @(posedge clk) disable iff (!rst_b)
    err != '0 |=> (event_status_register_reg[5:3]
      & $past({err.cmd_err, err.exec_err, err.query_err}))
      == $past({err.cmd_err, err.exec_err, err.query_err});
  endproperty
  a_err_bits: assert property (p_err_bits)
    else $error("error event bit not set");

  // Event mask query answers without changing the mask
  property p_evmask_q;
    @(posedge clk) disable iff (!rst_b)
    act && cmd.op == gsr_pkg::gsr_evmask_qry
      |=> rsp.valid && rsp.value == $past(event_enable_mask_reg)
        && $stable(event_enable_mask_reg);
  endproperty
  a_evmask_q: assert property (p_evmask_q)
    else $error("event mask query wrong");

  // Rising interface enable sets event bit 7
  property p_gpib_edge;
    @(posedge clk) disable iff (!rst_b)
    gpib_seen_reg && gpib_enabled && !gpib_en_reg
      |=> event_status_register_reg[`GSR_EVT_PWR_BIT];
  endproperty
  a_gpib_edge: assert property (p_gpib_edge)
    else $error("interface enable did not set bit 7");
endmodule : gsr_status

// ===== gsr_ctrl_model.sv
// Remote bus controller model: issues one decoded command per call.
// Assumes the block takes cmd on the rising edge of clk.
module gsr_ctrl_model
(
  // Clock
  input wire logic clk,
  // Command out
  output gsr_pkg::gsr_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle command bus at time zero
  initial
  begin
    cmd = '0;
  end

  // One-cycle command pulse; the payload is scrambled once released
  task send(input gsr_pkg::gsr_op_type op, input logic [7:0] val,
    input logic gpib);
    @(posedge clk);
    #5;
    cmd = '{valid: 1'b1, from_gpib: gpib, op: op, value: val};
    @(posedge clk);
    #5;
    cmd.valid = 1'b0;
    cmd.value = ~val;
  endtask : send
endmodule : gsr_ctrl_model

// ===== testbench.sv
// Self-checking bench for the status-reporting block.
// Assumes gsr_pkg, gsr_status and gsr_ctrl_model are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_b;
  gsr_pkg::gsr_cmd_type cmd;
  gsr_pkg::gsr_rsp_type rsp;
  gsr_pkg::gsr_err_type err;
  logic msg_avail;
  logic gpib_enabled;
  logic [7:0] condition_register;
  logic [7:0] status_byte;
  logic service_request;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  // Controller model and block under test
  gsr_ctrl_model ctrl (.clk(clk), .cmd(cmd));
  gsr_status uut (.clk(clk), .rst_b(rst_b), .cmd(cmd), .rsp(rsp),
    .err(err), .msg_avail(msg_avail), .gpib_enabled(gpib_enabled),
    .condition_register(condition_register),
    .status_byte(status_byte), .service_request(service_request));

  // Compare one byte and report a mismatch
  task check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Let n edges pass, then settle
  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step

  // Issue a query and compare the single answer
  task query(input gsr_pkg::gsr_op_type op, input logic [7:0] exp);
    int k;
    k = 0;
    ctrl.send(op, 8'h00, 1'b1);
    while (rsp.valid !== 1'b1 && k < 3)
    begin
      step(1);
      k++;
    end
    check("answer valid", {7'h00, rsp.valid}, 8'h01);
    check(op.name(), rsp.value, exp);
  endtask : query

  // Counts and verdict
  task conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
  end
  always #25 clk = ~clk;

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      conclude();
    end
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    err = '0;
    msg_avail = 1'b0;
    gpib_enabled = 1'b1;
    condition_register = 8'h00;
    step(4);
    rst_b = 1'b1;
    query(gsr_pkg::gsr_evmask_qry, 8'h00);
    query(gsr_pkg::gsr_srmask_qry, 8'h00);
    query(gsr_pkg::gsr_condmask_qry, 8'h00);
    query(gsr_pkg::gsr_event_qry, 8'h80);
    query(gsr_pkg::gsr_event_qry, 8'h00);
    query(gsr_pkg::gsr_tst_qry, 8'h00);
    $display("test reset done");
    // Off-bus set is dropped, wait answers nothing
    ctrl.send(gsr_pkg::gsr_evmask_set, 8'hff, 1'b0);
    ctrl.send(gsr_pkg::gsr_wai_type_c, 8'h55, 1'b1);
    check("wait answer", {7'h00, rsp.valid}, 8'h00);
    query(gsr_pkg::gsr_evmask_qry, 8'h00);
    query(gsr_pkg::gsr_tst_qry, 8'h00);
    $display("test fixed commands done");
    // Operation complete through both masks to a service request
    ctrl.send(gsr_pkg::gsr_evmask_set, 8'h01, 1'b1);
    ctrl.send(gsr_pkg::gsr_srmask_set, 8'h20, 1'b1);
    ctrl.send(gsr_pkg::gsr_opc, 8'h00, 1'b1);
    step(2);
    check("status byte", status_byte, 8'h60);
    check("request", {7'h00, service_request}, 8'h01);
    query(gsr_pkg::gsr_status_qry, 8'h60);
    query(gsr_pkg::gsr_evmask_qry, 8'h01);
    query(gsr_pkg::gsr_evmask_qry, 8'h01);
    query(gsr_pkg::gsr_srmask_qry, 8'h20);
    query(gsr_pkg::gsr_event_qry, 8'h01);
    step(2);
    check("status byte", status_byte, 8'h00);
    check("request", {7'h00, service_request}, 8'h00);
    $display("test events done");
    // Each error source lands on its own event bit
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      #5;
      err = gsr_pkg::gsr_err_type'(3'h4 >> i);
      step(1);
      err = '0;
      query(gsr_pkg::gsr_event_qry, 8'h08 << i);
    end
    // An event taken at the clearing read's edge survives the clear
    fork
      ctrl.send(gsr_pkg::gsr_event_qry, 8'h00, 1'b1);
      begin
        @(posedge clk);
        #5;
        err = gsr_pkg::gsr_err_type'(3'h1);
        @(posedge clk);
        #5;
        err = '0;
      end
    join
    check("read valid", {7'h00, rsp.valid}, 8'h01);
    check("read answer", rsp.value, 8'h00);
    query(gsr_pkg::gsr_event_qry, 8'h20);
    $display("test errors done");
    // Condition and message-available bits
    ctrl.send(gsr_pkg::gsr_condmask_set, 8'h05, 1'b1);
    ctrl.send(gsr_pkg::gsr_srmask_set, 8'h11, 1'b1);
    condition_register = 8'h02;
    step(2);
    check("status byte", status_byte, 8'h00);
    condition_register = 8'h04;
    msg_avail = 1'b1;
    step(2);
    check("status byte", status_byte, 8'h51);
    check("request", {7'h00, service_request}, 8'h01);
    query(gsr_pkg::gsr_condmask_qry, 8'h05);
    $display("test conditions done");
    // Interface enable edge, then a second reset
    gpib_enabled = 1'b0;
    step(2);
    gpib_enabled = 1'b1;
    step(2);
    query(gsr_pkg::gsr_event_qry, 8'h80);
    rst_b = 1'b0;
    step(1);
    rst_b = 1'b1;
    query(gsr_pkg::gsr_srmask_qry, 8'h00);
    query(gsr_pkg::gsr_condmask_qry, 8'h00);
    query(gsr_pkg::gsr_event_qry, 8'h80);
    $display("test enable and reset done");
    conclude();
  end
endmodule : testbench
